// ===== hw/fmfa_cfg.svh
// fmfa_cfg.svh - register map, field positions, reset values and rates
// for the fsk modem core; assumes a 32-bit apb with byte addresses.
`ifndef FMFA_CFG_SVH
`define FMFA_CFG_SVH

// =====================================================================
// register byte offsets
`define FMFA_OFF_MODEM_CFG 8'h00
`define FMFA_OFF_FIFO_CFG 8'h04
`define FMFA_OFF_MASK 8'h08
`define FMFA_OFF_STATUS 8'h0C
`define FMFA_OFF_TX_WR 8'h10
`define FMFA_OFF_RX_POP 8'h14

// =====================================================================
// modem configuration bits
`define FMFA_CFG_RTS 0
`define FMFA_CFG_FINE 1
`define FMFA_CFG_OUTFILT 2
`define FMFA_CFG_LPF 3
`define FMFA_CFG_INLOOP 4
`define FMFA_CFG_OUTLOOP 5
`define FMFA_CFG_RST 6'h00

// queue configuration: rx threshold [3:0], tx threshold [7:4]
`define FMFA_RX_THR_RST 4'hF
`define FMFA_TX_THR_RST 4'h0
`define FMFA_MASK_RST 1'b1

// =====================================================================
// rx pop read-back layout: data [8:0], empty 9, full 10, level [14:11]
`define FMFA_POP_EMPTY 9
`define FMFA_POP_FULL 10
`define FMFA_POP_LVL 11

// =====================================================================
// rates in hertz
`define FMFA_CLK_HZ 125000000
`define FMFA_BAUD_HZ 1200
`define FMFA_MARK_HZ 1200
`define FMFA_SPACE_HZ 2200
`define FMFA_COARSE_STEPS 32
`define FMFA_FINE_STEPS 128

// carrier detect hysteresis on the amplitude input
`define FMFA_CD_ON_LVL 8'h40
`define FMFA_CD_OFF_LVL 8'h30

// quarter sine, entries 0..32 from the low byte up, scaled to 127
`define FMFA_QSINE 264'h7F7F7E7E7D7B7A7875737_06D6A66625E5A55514C47413C36312B251F19130C0600

`endif

// ===== hw/fmfa_pkg.sv
// fmfa_pkg.sv - types shared by the fsk modem core
// assumes nothing of its surroundings.
package fmfa_pkg;
   // arbiter states
   typedef enum logic [0:0] {
      FMFA_RECEIVE,
      FMFA_SEND
   } fmfa_state_t;
endpackage

// ===== hw/fmfa_core.sv
// fmfa_core.sv - fsk modem queues, modulator, carrier detect and the
// send arbiter, with an apb register slave.
// assumes synchronous inputs on mclk_i and a demodulator front end that
// delivers whole 9-bit characters and a carrier amplitude.
`timescale 1ns/1ns
`default_nettype none
`include "fmfa_cfg.svh"

// =====================================================================
// fifo of flip-flops
module fmfa_queue #(
   parameter int DEPTH = 32,
   parameter int WIDTH = 9
) (
   input wire logic mclk_i,                 // clock
   input wire logic sys_rst_i,              // sync reset
   input wire logic push_i,                 // enqueue strobe
   input wire logic [WIDTH-1:0] data_i,     // enqueue data
   input wire logic pop_i,                  // dequeue strobe
   output logic [WIDTH-1:0] head_o,         // oldest entry
   output logic [$clog2(DEPTH):0] count_o   // occupancy
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic do_push;
   logic do_pop;

   // a full queue drops the newcomer so stored entries stay intact
   assign do_push = push_i && (cnt_q != (AW+1)'(DEPTH));
   assign do_pop = pop_i && (cnt_q != '0);
   assign head_o = mem_q[rd_q];
   assign count_o = cnt_q;

   // storage
   always_ff @(posedge mclk_i) begin
      if (do_push) begin
         mem_q[wr_q] <= data_i;
      end
   end

   // pointers and occupancy
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (do_push) begin
            wr_q <= wr_q + AW'(1);
         end
         if (do_pop) begin
            rd_q <= rd_q + AW'(1);
         end
         if (do_push && !do_pop) begin
            cnt_q <= cnt_q + (AW+1)'(1);
         end else if (do_pop && !do_push) begin
            cnt_q <= cnt_q - (AW+1)'(1);
         end
      end
   end
endmodule

// Behaviour
// - rx pop status shows queue before the pop; empty marks data invalid
// - read-back level is occupancy bits 4..1, so 0, 1 and 32 read zero
// - rx threshold hit when occupancy exceeds setting with a 1 appended
// - a full queue discards new bytes and keeps stored ones
// - tx threshold hit when occupancy is below setting with a 0 appended
// - unmasked tx threshold hit drives the interrupt output
// - 128-entry signed 8-bit sine table stepped by a counter to the output
// - step rate is steps per period times 1200 or 2200 hertz
// - 32 samples per period by default, all 128 when fine steps set
// - a configuration bit selects outboard or internal input filtering
// - a configuration bit enables the second-order low-pass stage
// - glitch-free carrier detect with hysteresis, used inside and on a pin
// - half duplex never enables both; demodulator active after reset
// - inner loop enables both and routes modulator output to filtered input
// - outboard loop enables both with no internal connection
// - idle: request inactive, carrier low, demodulator on, modulator off
// - with carrier present stay receiving and enqueue demodulated bytes
// - request without carrier drops detect, stops demod, grants, modulates
// - while carrier present the request waits and tx bytes only queue
// - once granted send queued bytes, else a continuous mark tone
// - each queue holds 32 entries of parity bit plus data byte
module fmfa_core
   import fmfa_pkg::*;
#(
   parameter int DEPTH = 32,
   parameter int CLK_HZ = `FMFA_CLK_HZ
) (
   input wire logic mclk_i,              // 125 mhz clock
   input wire logic sys_rst_i,           // sync reset, active high
   input wire logic psel_i,              // apb select
   input wire logic penable_i,           // apb enable
   input wire logic pwrite_i,            // apb direction
   input wire logic [7:0] paddr_i,       // apb byte address
   input wire logic [31:0] pwdata_i,     // apb write data
   output logic [31:0] prdata_o,         // apb read data
   output logic pready_o,                // apb ready
   output logic pslverr_o,               // apb error, unmapped address
   input wire logic send_req_n_i,        // send request pin, low active
   input wire logic [7:0] carrier_lvl_i, // carrier amplitude from front end
   input wire logic demod_valid_i,       // demodulated character strobe
   input wire logic [8:0] demod_char_i,  // parity and data byte
   output logic [7:0] fsk_out_o,         // signed sample to the converter
   output logic carrier_present_o,       // carrier detect pin
   output logic mod_en_o,                // modulator enable
   output logic demod_en_o,              // demodulator enable
   output logic rx_outboard_filter_sel_o, // use filtered input pin only
   output logic rx_lowpass_stage_en_o,   // second-order low-pass on
   output logic loop_route_o,            // modulator to filtered input
   output logic irq_o                    // interrupt pin, active high
);
   localparam int CW = $clog2(DEPTH) + 1;
   localparam int ACC_W = 28;
   localparam logic [ACC_W-1:0] CLK_W = ACC_W'(CLK_HZ);
   localparam logic [ACC_W-1:0] BAUD_INC = ACC_W'(`FMFA_BAUD_HZ);
   localparam logic [ACC_W-1:0] INC_C1 =
      ACC_W'(`FMFA_COARSE_STEPS * `FMFA_MARK_HZ);
   localparam logic [ACC_W-1:0] INC_C0 =
      ACC_W'(`FMFA_COARSE_STEPS * `FMFA_SPACE_HZ);
   localparam logic [ACC_W-1:0] INC_F1 =
      ACC_W'(`FMFA_FINE_STEPS * `FMFA_MARK_HZ);
   localparam logic [ACC_W-1:0] INC_F0 =
      ACC_W'(`FMFA_FINE_STEPS * `FMFA_SPACE_HZ);
   localparam logic [263:0] QSINE = `FMFA_QSINE;

   // level read-back and thresholds rely on a 32-entry queue
   if (DEPTH != 32) begin : g_bad_depth
      $error("fmfa_core: DEPTH must be 32");
   end
   if (CLK_HZ < 2 * `FMFA_FINE_STEPS * `FMFA_SPACE_HZ) begin : g_bad_clk
      $error("fmfa_core: clock too slow for the sine stepping");
   end

   // =====================================================================
   // declarations
   fmfa_state_t state_q;
   logic [5:0] cfg_q;
   logic [3:0] rx_thr_q;
   logic [3:0] tx_thr_q;
   logic mask_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic pop_empty_q;
   logic [31:0] rd_mux;
   logic mapped;
   logic setup;
   logic done;
   logic cd_q;
   logic cts_q;
   logic req;
   logic loop_any;
   logic mod_on;
   logic demod_on;
   logic rx_push;
   logic rx_pop;
   logic tx_push;
   logic tx_pop;
   logic [8:0] rx_head;
   logic [8:0] tx_head;
   logic [CW-1:0] rx_cnt;
   logic [CW-1:0] tx_cnt;
   logic rx_hit;
   logic tx_hit;
   logic [ACC_W-1:0] baud_acc_q;
   logic [ACC_W-1:0] baud_sum;
   logic baud_tick;
   logic [ACC_W-1:0] step_acc_q;
   logic [ACC_W-1:0] step_inc;
   logic [ACC_W-1:0] step_sum;
   logic step_tick;
   logic [9:0] frame_q;
   logic [3:0] bits_left_q;
   logic tone_bit_q;
   logic [6:0] phase_q;
   logic [4:0] q_idx;
   logic [7:0] q_mag;

   // =====================================================================
   // queues
   fmfa_queue #(.DEPTH(DEPTH), .WIDTH(9)) u_rx_queue (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .push_i(rx_push),
      .data_i(demod_char_i),
      .pop_i(rx_pop),
      .head_o(rx_head),
      .count_o(rx_cnt)
   );

   fmfa_queue #(.DEPTH(DEPTH), .WIDTH(9)) u_tx_queue (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .push_i(tx_push),
      .data_i(pwdata_i[8:0]),
      .pop_i(tx_pop),
      .head_o(tx_head),
      .count_o(tx_cnt)
   );

   // threshold flags; the appended bit widens the 4-bit setting to 5
   assign rx_hit = rx_cnt > CW'({rx_thr_q, 1'b1});
   assign tx_hit = tx_cnt < CW'({tx_thr_q, 1'b0});

   // =====================================================================
   // apb slave: data is latched in setup, pready follows one cycle later
   assign setup = psel_i && !penable_i;
   assign done = psel_i && penable_i && pready_q;
   assign mapped = (paddr_i[1:0] == 2'b00) && (paddr_i <= `FMFA_OFF_RX_POP);
   assign tx_push = done && pwrite_i && (paddr_i == `FMFA_OFF_TX_WR);
   // pop only when the latched status said data was there, so the byte
   // popped is the byte returned even if the demod pushed meanwhile
   assign rx_pop = done && !pwrite_i && (paddr_i == `FMFA_OFF_RX_POP) &&
                   !pop_empty_q;

   // read multiplexer
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr_i)
         `FMFA_OFF_MODEM_CFG: rd_mux[5:0] = cfg_q;
         `FMFA_OFF_FIFO_CFG: rd_mux[7:0] = {tx_thr_q, rx_thr_q};
         `FMFA_OFF_MASK: rd_mux[0] = mask_q;
         `FMFA_OFF_STATUS: begin
            rd_mux[7:0] = {tx_cnt == CW'(DEPTH), tx_cnt == '0,
                           rx_cnt == CW'(DEPTH), rx_cnt == '0,
                           tx_hit, rx_hit, cd_q, cts_q};
            rd_mux[13:8] = 6'(rx_cnt);
            rd_mux[21:16] = 6'(tx_cnt);
         end
         // head is visible but a read here never dequeues
         `FMFA_OFF_TX_WR: rd_mux[8:0] = tx_head;
         `FMFA_OFF_RX_POP: begin
            rd_mux[8:0] = rx_head;
            rd_mux[`FMFA_POP_EMPTY] = (rx_cnt == '0);
            rd_mux[`FMFA_POP_FULL] = (rx_cnt == CW'(DEPTH));
            rd_mux[`FMFA_POP_LVL +: 4] = rx_cnt[4:1];
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // bus handshake and captured answer
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pop_empty_q <= 1'b1;
      end else begin
         pready_q <= setup;
         if (setup) begin
            pslverr_q <= !mapped;
            prdata_q <= pwrite_i ? 32'h0000_0000 : rd_mux;
            pop_empty_q <= (rx_cnt == '0);
         end else if (done) begin
            pslverr_q <= 1'b0;
         end
      end
   end

   // software registers; a write to the rx pop word is ignored
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         cfg_q <= `FMFA_CFG_RST;
         rx_thr_q <= `FMFA_RX_THR_RST;
         tx_thr_q <= `FMFA_TX_THR_RST;
         mask_q <= `FMFA_MASK_RST;
      end else if (done && pwrite_i) begin
         case (paddr_i)
            `FMFA_OFF_MODEM_CFG: cfg_q <= pwdata_i[5:0];
            `FMFA_OFF_FIFO_CFG: begin
               rx_thr_q <= pwdata_i[3:0];
               tx_thr_q <= pwdata_i[7:4];
            end
            `FMFA_OFF_MASK: mask_q <= pwdata_i[0];
            default: ;
         endcase
      end
   end

   // =====================================================================
   // carrier detect and arbiter
   assign loop_any = cfg_q[`FMFA_CFG_INLOOP] || cfg_q[`FMFA_CFG_OUTLOOP];
   assign req = !send_req_n_i || cfg_q[`FMFA_CFG_RTS];
   // loops enable both ends; otherwise exactly one is on
   assign mod_on = loop_any || (state_q == FMFA_SEND);
   assign demod_on = loop_any || (state_q == FMFA_RECEIVE);
   assign rx_push = demod_valid_i && demod_on && cd_q;

   // hysteresis: separate on and off levels stop chatter; registered so
   // the pin and the arbiter see one clean level
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         cd_q <= 1'b0;
      end else if (!demod_on) begin
         cd_q <= 1'b0;
      end else if (carrier_lvl_i >= `FMFA_CD_ON_LVL) begin
         cd_q <= 1'b1;
      end else if (carrier_lvl_i < `FMFA_CD_OFF_LVL) begin
         cd_q <= 1'b0;
      end
   end

   // receive has priority: a request waits while carrier is present;
   // in a loop the carrier is our own, so it does not hold the request
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state_q <= FMFA_RECEIVE;
         cts_q <= 1'b0;
      end else begin
         case (state_q)
            FMFA_RECEIVE: begin
               if (req && (!cd_q || loop_any)) begin
                  state_q <= FMFA_SEND;
                  cts_q <= 1'b1;
               end
            end
            FMFA_SEND: begin
               if (!req) begin
                  state_q <= FMFA_RECEIVE;
                  cts_q <= 1'b0;
               end
            end
            default: begin
               state_q <= FMFA_RECEIVE;
               cts_q <= 1'b0;
            end
         endcase
      end
   end

   // =====================================================================
   // modulator bit engine: 11-bit characters, mark when the queue is dry
   assign baud_sum = baud_acc_q + BAUD_INC;
   assign baud_tick = mod_on && (baud_sum >= CLK_W);
   assign tx_pop = baud_tick && (bits_left_q == 4'h0) && (tx_cnt != '0) &&
                   (mod_on && cts_q || loop_any && req);

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || !mod_on) begin
         baud_acc_q <= '0;
         bits_left_q <= 4'h0;
         frame_q <= 10'h3FF;
         tone_bit_q <= 1'b1;
      end else begin
         baud_acc_q <= baud_tick ? baud_sum - CLK_W : baud_sum;
         if (baud_tick) begin
            if (bits_left_q != 4'h0) begin
               tone_bit_q <= frame_q[0];
               frame_q <= {1'b1, frame_q[9:1]};
               bits_left_q <= bits_left_q - 4'h1;
            end else if (tx_pop) begin
               tone_bit_q <= 1'b0; // start bit
               frame_q <= {1'b1, tx_head}; // data lsb first, parity, stop
               bits_left_q <= 4'hA;
            end else begin
               tone_bit_q <= 1'b1;
            end
         end
      end
   end

   // table stepping: phase accumulator at steps times tone frequency
   always_comb begin
      case ({cfg_q[`FMFA_CFG_FINE], tone_bit_q})
         2'b00: step_inc = INC_C0;
         2'b01: step_inc = INC_C1;
         2'b10: step_inc = INC_F0;
         2'b11: step_inc = INC_F1;
         default: step_inc = INC_C1;
      endcase
   end
   assign step_sum = step_acc_q + step_inc;
   assign step_tick = step_sum >= CLK_W;

   // coarse mode skips three of four entries to save power
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || !mod_on) begin
         step_acc_q <= '0;
         phase_q <= 7'h00;
      end else begin
         step_acc_q <= step_tick ? step_sum - CLK_W : step_sum;
         if (step_tick) begin
            phase_q <= phase_q + (cfg_q[`FMFA_CFG_FINE] ? 7'h01 : 7'h04);
         end
      end
   end

   // 128-entry sine folded from a quarter wave
   assign q_idx = phase_q[5] ? 5'(6'h20 - {1'b0, phase_q[4:0]}) : phase_q[4:0];
   assign q_mag = (phase_q[5] && phase_q[4:0] == 5'h00) ?
                  QSINE[32*8 +: 8] : QSINE[q_idx*8 +: 8];

   // =====================================================================
   // registered outputs
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         fsk_out_o <= 8'h00;
         mod_en_o <= 1'b0;
         demod_en_o <= 1'b1;
         carrier_present_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         fsk_out_o <= !mod_on ? 8'h00 :
                      phase_q[6] ? 8'(-q_mag) : q_mag;
         mod_en_o <= mod_on;
         demod_en_o <= demod_on;
         carrier_present_o <= cd_q;
         irq_o <= tx_hit && !mask_q;
      end
   end

   // filter and loop controls to the analog front end
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rx_outboard_filter_sel_o <= 1'b0;
         rx_lowpass_stage_en_o <= 1'b0;
         loop_route_o <= 1'b0;
      end else begin
         rx_outboard_filter_sel_o <= cfg_q[`FMFA_CFG_OUTFILT];
         rx_lowpass_stage_en_o <= cfg_q[`FMFA_CFG_LPF];
         loop_route_o <= cfg_q[`FMFA_CFG_INLOOP];
      end
   end

   // apb outputs
   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
endmodule
`default_nettype wire

// ===== sim/fmfa_core_monitor.sv
// fmfa_core_monitor.sv - port-level assertions for the fsk modem core
// assumes it is bound onto fmfa_core and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module fmfa_core_monitor #(
   parameter int DEPTH = 32
) (
   input wire logic mclk_i,              // clock
   input wire logic sys_rst_i,           // sync reset
   input wire logic psel_i,              // apb select
   input wire logic penable_i,           // apb enable
   input wire logic pwrite_i,            // apb direction
   input wire logic [7:0] paddr_i,       // apb address
   input wire logic [31:0] prdata_o,     // apb read data
   input wire logic pready_o,            // apb ready
   input wire logic pslverr_o,           // apb error
   input wire logic [7:0] carrier_lvl_i, // carrier amplitude
   input wire logic [7:0] fsk_out_o,     // sine sample
   input wire logic carrier_present_o,   // carrier detect
   input wire logic mod_en_o,            // modulator enable
   input wire logic demod_en_o           // demodulator enable
);
   // ==================================================================
   // one clock domain, so clocking and reset are declared once
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   ready_after_setup_a: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no ready after setup");
   bad_addr_err_a: assert property (psel_i && penable_i && pready_o &&
      paddr_i > 8'h14 |-> pslverr_o) else $error("no error on unmapped");
   // pop flags describe the queue before the pop
   pop_empty_a: assert property (psel_i && pready_o && !pwrite_i &&
      paddr_i == 8'h14 && prdata_o[9] |-> prdata_o[14:10] == 5'h00)
      else $error("empty pop with level or full set");
   pop_full_a: assert property (psel_i && pready_o && !pwrite_i &&
      paddr_i == 8'h14 && prdata_o[10] |->
      prdata_o[14:11] == 4'h0 && !prdata_o[9])
      else $error("full pop with nonzero level");
   // hysteresis: rise at 0x40, hold down to 0x30, drop below it
   cd_rise_a: assert property ((demod_en_o &&
      carrier_lvl_i >= 8'h40)[*3] |-> carrier_present_o)
      else $error("carrier not detected");
   cd_hold_a: assert property (carrier_present_o && demod_en_o &&
      $past(carrier_lvl_i) >= 8'h30 |=> carrier_present_o)
      else $error("carrier detect glitched");
   cd_drop_a: assert property ((carrier_lvl_i < 8'h30)[*3]
      |-> !carrier_present_o) else $error("carrier detect stuck");
   tx_quiet_a: assert property ((mod_en_o && !demod_en_o)[*3]
      |-> !carrier_present_o) else $error("detect high while sending");
   fsk_idle_a: assert property ((!mod_en_o)[*3] |->
      fsk_out_o == 8'h00) else $error("tone while modulator off");
   swap_a: assert property ($fell(demod_en_o) |-> mod_en_o)
      else $error("demodulator off without modulator");

   cover property (psel_i && penable_i && pready_o && pslverr_o);
   cover property ($rose(carrier_present_o));
   cover property (mod_en_o && !demod_en_o);
endmodule

bind fmfa_core fmfa_core_monitor #(.DEPTH(DEPTH)) u_mon (
   .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .carrier_lvl_i(carrier_lvl_i), .fsk_out_o(fsk_out_o),
   .carrier_present_o(carrier_present_o), .mod_en_o(mod_en_o),
   .demod_en_o(demod_en_o));
`default_nettype wire

// ===== sim/fmfa_front.sv
// fmfa_front.sv - behavioural line front end: carrier level and characters
// assumes the bench calls its tasks; changes land after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module fmfa_front (
   input wire logic mclk_i,          // clock
   output logic [7:0] carrier_lvl_o, // carrier amplitude
   output logic demod_valid_o,       // character strobe
   output logic [8:0] demod_char_o   // parity and data
);
   // ==================================================================
   // quiet line at time zero
   initial begin
      carrier_lvl_o = 8'h00;
      demod_valid_o = 1'b0;
      demod_char_o = 9'h155;
   end

   task automatic set_lvl(input logic [7:0] lvl);
      @(posedge mclk_i);
      carrier_lvl_o <= lvl;
   endtask

   // the bus shows the inverse afterwards, so a stale byte is never fresh
   task automatic send_char(input logic [8:0] ch);
      @(posedge mclk_i);
      demod_valid_o <= 1'b1;
      demod_char_o <= ch;
      @(posedge mclk_i);
      demod_valid_o <= 1'b0;
      demod_char_o <= ~ch;
   endtask
endmodule
`default_nettype wire

// ===== sim/fmfa_core_bench.sv
// fmfa_core_bench.sv - self-checking bench for the fsk modem core
// assumes fmfa_core and the front end model; apb master drives registers.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
   n_mismatch++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module fmfa_core_bench import fmfa_pkg::*;;
   logic mclk_i, sys_rst_i, psel, penable, pwrite, pready, pslverr, err;
   logic send_req_n, dval, carrier, mod_en, demod_en, filt, lpf, route, irq;
   logic [7:0] paddr, lvl, fsk_out;
   logic [31:0] pwdata, prdata, rd;
   logic [8:0] dchar;
   logic [5:0] cnt;
   logic [4:0] modes [2:5] = '{5'b01010, 5'b01001, 5'b11100, 5'b11000};
   int n_mismatch, n_compared, cyc, n;

   // ==================================================================
   // lowered clock rate makes a baud about 833 cycles
   fmfa_core #(.DEPTH(32), .CLK_HZ(1000000)) dut (.mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .send_req_n_i(send_req_n), .carrier_lvl_i(lvl),
      .demod_valid_i(dval), .demod_char_i(dchar), .fsk_out_o(fsk_out),
      .carrier_present_o(carrier), .mod_en_o(mod_en),
      .demod_en_o(demod_en), .rx_outboard_filter_sel_o(filt),
      .rx_lowpass_stage_en_o(lpf), .loop_route_o(route), .irq_o(irq));
   fmfa_front u_fe (.mclk_i(mclk_i), .carrier_lvl_o(lvl),
      .demod_valid_o(dval), .demod_char_o(dchar));

   initial begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end

   // hang guard
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end

   function automatic logic [8:0] rxc(input int i);
      return {i[0], i[7:0] + 8'h30};
   endfunction

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // one transfer; ready, data and error are taken at the same rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge mclk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      penable <= 1'b1;
      do begin
         @(posedge mclk_i);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) n_mismatch++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic tick(input int c);
      repeat (c) @(posedge mclk_i);
      @(negedge mclk_i);
   endtask

   // first nonzero sample after the modulator starts from phase zero
   task automatic tone(input logic [7:0] ex);
      n = 0;
      while (fsk_out === 8'h00 && n < 300) begin
         tick(1);
         n++;
      end
      `CHK("tone", ex, fsk_out)
   endtask

   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      send_req_n = 1'b1;
      sys_rst_i = 1'b1;
      repeat (2) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      apb(0, 8'h00, 0);
      `CHK("modem cfg", 32'h0, rd)
      apb(0, 8'h04, 0);
      `CHK("fifo cfg", 32'h0F, rd)
      apb(0, 8'h08, 0);
      `CHK("mask", 32'h1, rd)
      apb(0, 8'h0C, 0);
      `CHK("status", 32'h50, rd)
      tick(1);
      `CHK("idle enables", 3'b010, {mod_en, demod_en, carrier})
      apb(0, 8'h18, 0);
      `CHK("unmapped", 1'b1, err)
      $display("test reset done");
      // receive: fill past full, then drain with threshold 8
      apb(1, 8'h04, 32'h28);
      u_fe.set_lvl(8'h40);
      tick(3);
      `CHK("carrier up", 1'b1, carrier)
      u_fe.set_lvl(8'h35);
      for (int i = 0; i < 33; i++) u_fe.send_char(i == 32 ? 9'h1FF : rxc(i));
      apb(0, 8'h0C, 0);
      `CHK("rx full", 7'h60, {rd[5], rd[13:8]})
      for (int i = 0; i < 32; i++) begin
         cnt = 6'(32 - i);
         apb(0, 8'h14, 0);
         `CHK("pop data", rxc(i), rd[8:0])
         `CHK("pop flags", {cnt[4:1], cnt[5], 1'b0}, rd[14:9])
         apb(0, 8'h0C, 0);
         `CHK("rx level", {cnt > 6'd18, cnt - 6'd1}, {rd[2], rd[13:8]})
      end
      apb(0, 8'h14, 0);
      `CHK("pop empty", 6'h01, rd[14:9])
      `CHK("carrier held", 1'b1, carrier)
      $display("test receive done");
      // request while carrier: bytes only queue
      @(posedge mclk_i);
      send_req_n <= 1'b0;
      for (int i = 0; i < 3; i++) apb(1, 8'h10, 32'h0C0 + 32'(i));
      apb(0, 8'h0C, 0);
      `CHK("pending", 8'h43, {rd[0], rd[3], rd[21:16]})
      apb(1, 8'h08, 0);
      tick(2);
      `CHK("irq on", 1'b1, irq)
      apb(1, 8'h08, 1);
      tick(2);
      `CHK("irq off", 1'b0, irq)
      for (int i = 3; i < 33; i++) apb(1, 8'h10, 32'h0C0 + 32'(i));
      apb(0, 8'h0C, 0);
      `CHK("tx full", 9'h0A0, {rd[0], rd[7], rd[3], rd[21:16]})
      apb(0, 8'h10, 0);
      `CHK("tx head", 9'h0C0, rd[8:0])
      `CHK("held enables", 2'b01, {mod_en, demod_en})
      $display("test pending done");
      // carrier gone: grant and send
      u_fe.set_lvl(8'h00);
      tick(5);
      `CHK("send", 3'b100, {mod_en, demod_en, carrier})
      apb(0, 8'h0C, 0);
      `CHK("cts", 1'b1, rd[0])
      tone(8'h19);
      n = 0;
      do begin
         apb(0, 8'h0C, 0);
         n++;
      end while (rd[21:16] === 6'd32 && n < 1000);
      `CHK("dequeue", 6'd31, rd[21:16])
      apb(0, 8'h10, 0);
      `CHK("next head", 9'h0C1, rd[8:0])
      @(posedge mclk_i);
      send_req_n <= 1'b1;
      tick(3);
      `CHK("back to rx", 2'b01, {mod_en, demod_en})
      apb(1, 8'h00, 3);
      tick(3);
      apb(0, 8'h0C, 0);
      `CHK("cts by bit", 1'b1, rd[0])
      tone(8'h06);
      $display("test send done");
      // loop and filter modes, one bit at a time
      for (int k = 2; k < 6; k++) begin
         apb(1, 8'h00, 32'h1 << k);
         tick(3);
         `CHK("mode", modes[k], {mod_en, demod_en, route, filt, lpf})
      end
      apb(1, 8'h00, 0);
      $display("test modes done");
      end_sim();
   end
endmodule
`undef CHK
`default_nettype wire
